/* File: logic/hbsp_pkg.sv */
// package for the host bus strap decoder and panel pin map
// assumes one clock domain, no software registers reached from outside
package hbsp_pkg;
  // host bus variants decoded from straps
  typedef enum logic [2:0] {
    HBSP_BUS_A = 3'h0,
    HBSP_BUS_B = 3'h1,
    HBSP_BUS_ASYNC1 = 3'h2,
    HBSP_BUS_ASYNC2 = 3'h3,
    HBSP_BUS_GEN1 = 3'h4,
    HBSP_BUS_GEN2 = 3'h5,
    HBSP_BUS_RSVD = 3'h7
  } hbsp_bus_e;

  // panel type selection
  typedef enum logic [2:0] {
    HBSP_PNL_MONO4 = 3'h0,
    HBSP_PNL_MONO8 = 3'h1,
    HBSP_PNL_MONO8D = 3'h2,
    HBSP_PNL_COL4 = 3'h3,
    HBSP_PNL_COL8F1 = 3'h4,
    HBSP_PNL_COL8F2 = 3'h5,
    HBSP_PNL_COL8D = 3'h6,
    HBSP_PNL_TFT = 3'h7
  } hbsp_pnl_e;

  typedef struct packed {
    hbsp_bus_e bus;
    logic big_endian;
    logic reserved;
  } hbsp_cfg_s;

  localparam logic [2:0] HBSP_CODE_A = 3'h0;
  localparam logic [2:0] HBSP_CODE_B = 3'h1;
  localparam logic [2:0] HBSP_CODE_ASYNC1 = 3'h3;
  localparam logic [2:0] HBSP_CODE_ASYNC2 = 3'h5;
  localparam logic [2:0] HBSP_CODE_GEN = 3'h7;
  localparam int HBSP_ENDIAN_BIT = 3;
  localparam int HBSP_INVERT_CTRL_BIT = 1;
  localparam int HBSP_PANEL_WIDTH = 12;
  localparam logic [7:0] HBSP_CTRL_RESET = 8'h00;
  // pins 7..0 drive low in reset, pins 11..8 are released to the board pull-ups
  localparam logic [11:0] HBSP_DAT_RESET = 12'h000;
  localparam logic [11:0] HBSP_OE_N_RESET = 12'hF00;
  localparam hbsp_cfg_s HBSP_CFG_RESET = '{bus: HBSP_BUS_RSVD, big_endian: 1'b0, reserved: 1'b1};
endpackage

/* File: logic/hbsp_strap_pin_map.sv */
// strap decoder and host/panel pin multiplexer
// assumes straps and pins are synchronous to clk_sys; control byte comes from the register file
// Notes on behaviour
// - straps and bus-start are caught after reset release, choosing bus and byte order
// - straps 2..0 all low: variant A, strap 3 picks endian
// - straps 2..0 = 001: variant B, strap 3 picks endian
// - code 011 with strap 3 high: async variant 1, big-endian; else reserved
// - code 101 with strap 3 high: async variant 2 sizing, big-endian; else reserved
// - code 111, bus-start low: generic 1, strap 3 picks endian
// - code 111, bus-start high, strap 3 low: generic 2 little-endian; high reserved
// - video invert taken from panel data bit 11 only while control bit 1 set and the panel type is not TFT
// - reset restores defaults and drives all outputs inactive except pins 7..0, which are driven low
`timescale 1ns/10ps
`default_nettype none
module hbsp_strap_pin_map
  import hbsp_pkg::*;
#(
  parameter int PANEL_WIDTH = HBSP_PANEL_WIDTH
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [3:0] config_straps,
  input wire logic bus_start_strobe_n,
  input wire logic [7:0] ctrl_reg,
  input wire hbsp_pnl_e panel_type,
  input wire logic [11:0] pixel_data,
  input wire logic [3:0] gpio_out,
  input wire logic [3:0] gpio_dir_out,
  input wire logic [PANEL_WIDTH-1:0] panel_data_bus_in,
  output logic [PANEL_WIDTH-1:0] panel_data_bus_out,
  output logic [PANEL_WIDTH-1:0] panel_data_bus_oe_n,
  output logic [3:0] gpio_in,
  output logic video_invert,
  output hbsp_cfg_s bus_cfg
);

  // routing below is written for exactly twelve panel pins
  if (PANEL_WIDTH != 12) begin : g_width_check
    $error("panel width must be 12");
  end

  hbsp_cfg_s cfg_q;
  logic caught_q;
  logic [PANEL_WIDTH-1:0] dat_q;
  logic [PANEL_WIDTH-1:0] oe_n_q;
  logic [3:0] gpio_in_q;
  logic inv_q;

  // invert is only offered where pin 11 is not panel data
  function automatic logic inv_enabled(input logic [7:0] ctrl, input hbsp_pnl_e pnl);
    return ctrl[HBSP_INVERT_CTRL_BIT] && (pnl != HBSP_PNL_TFT);
  endfunction

  function automatic hbsp_cfg_s decode(input logic [3:0] s, input logic bs);
    hbsp_cfg_s c;
    c = '{bus: HBSP_BUS_RSVD, big_endian: s[HBSP_ENDIAN_BIT], reserved: 1'b1};
    case (s[2:0])
      HBSP_CODE_A: begin
        c.bus = HBSP_BUS_A;
        c.reserved = 1'b0;
      end
      HBSP_CODE_B: begin
        c.bus = HBSP_BUS_B;
        c.reserved = 1'b0;
      end
      HBSP_CODE_ASYNC1: begin
        if (s[HBSP_ENDIAN_BIT]) begin
          c.bus = HBSP_BUS_ASYNC1;
          c.reserved = 1'b0;
        end
      end
      HBSP_CODE_ASYNC2: begin
        if (s[HBSP_ENDIAN_BIT]) begin
          c.bus = HBSP_BUS_ASYNC2;
          c.reserved = 1'b0;
        end
      end
      HBSP_CODE_GEN: begin
        if (!bs) begin
          c.bus = HBSP_BUS_GEN1;
          c.reserved = 1'b0;
        end else if (!s[HBSP_ENDIAN_BIT]) begin
          c.bus = HBSP_BUS_GEN2;
          c.reserved = 1'b0;
        end
      end
      default: begin
        c.bus = HBSP_BUS_RSVD;
      end
    endcase
    return c;
  endfunction

  // catch straps once
  // straps are board-fixed, so a single sample on the first edge after release is enough
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q <= HBSP_CFG_RESET;
      caught_q <= 1'b0;
    end else if (!caught_q) begin
      cfg_q <= decode(config_straps, bus_start_strobe_n);
      caught_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dat_q <= HBSP_DAT_RESET;
      oe_n_q <= HBSP_OE_N_RESET;
    end else begin
      dat_q[7:0] <= pixel_data[7:0];
      oe_n_q[7:0] <= 8'h00;
      dat_q[11:8] <= gpio_out;
      oe_n_q[11:8] <= ~gpio_dir_out;
      case (panel_type)
        HBSP_PNL_MONO4, HBSP_PNL_COL4: begin
          dat_q[7:0] <= {pixel_data[3:0], 4'h0};
        end
        HBSP_PNL_TFT: begin
          dat_q[11:8] <= pixel_data[11:8];
          oe_n_q[11:8] <= 4'h0;
        end
        default: begin
          dat_q[7:0] <= pixel_data[7:0];
        end
      endcase
      // invert pin stays input
      // invert input would fight a driven gpio, so the pin is released while enabled
      if (inv_enabled(ctrl_reg, panel_type)) begin
        oe_n_q[11] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      inv_q <= 1'b0;
      gpio_in_q <= 4'h0;
    end else begin
      inv_q <= inv_enabled(ctrl_reg, panel_type) && panel_data_bus_in[11];
      gpio_in_q <= panel_data_bus_in[11:8];
    end
  end

  assign panel_data_bus_out = dat_q;
  assign panel_data_bus_oe_n = oe_n_q;
  assign gpio_in = gpio_in_q;
  assign video_invert = inv_q;
  assign bus_cfg = cfg_q;

endmodule
`default_nettype wire

/* File: tb/hbsp_chk_checker.sv */
// checker for strap capture and pin routing
// assumes binding to the top module, one clock
`timescale 1ns/10ps
`default_nettype none
module hbsp_chk
  import hbsp_pkg::*;
#(parameter int PANEL_WIDTH = 12) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [3:0] config_straps,
  input wire logic bus_start_strobe_n,
  input wire logic [7:0] ctrl_reg,
  input wire hbsp_pnl_e panel_type,
  input wire logic [11:0] pixel_data,
  input wire logic [3:0] gpio_dir_out,
  input wire logic [PANEL_WIDTH-1:0] panel_data_bus_in,
  input wire logic [PANEL_WIDTH-1:0] panel_data_bus_out,
  input wire logic [PANEL_WIDTH-1:0] panel_data_bus_oe_n,
  input wire logic video_invert,
  input wire hbsp_cfg_s bus_cfg
);
  logic [1:0] age_q;
  // edges since reset; $past is only trusted once age is nonzero
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      age_q <= 2'h0;
    end else if (age_q != 2'h2) begin
      age_q <= age_q + 2'h1;
    end
  end
  // reset level at the previous edge; outputs are only reset once an edge has seen it
  logic rst_prev_q = 1'b0;
  always_ff @(posedge clk_sys) begin
    rst_prev_q <= sys_rst;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_rst_idle: assert property (disable iff (1'b0)
    sys_rst && rst_prev_q |-> panel_data_bus_oe_n == 12'hF00 && bus_cfg == HBSP_CFG_RESET)
    else $error("rst");
  chk_cfg_hold: assert property (
    age_q == 2'h2 |-> $stable(bus_cfg)) else $error("cfg moved");
  chk_cfg_endian: assert property (
    age_q == 2'h1 |-> bus_cfg.big_endian == $past(config_straps[3])) else $error("endian");
  chk_cfg_rsvd: assert property (
    age_q == 2'h1 && !$past(config_straps[0]) && $past(config_straps[2:1]) != 2'h0
    |-> bus_cfg.reserved) else $error("rsvd");
  chk_cfg_gen: assert property (
    age_q == 2'h1 && $past(config_straps) == 4'hF && !$past(bus_start_strobe_n)
    |-> bus_cfg.bus == HBSP_BUS_GEN1) else $error("gen1");
  chk_nib_low: assert property (
    age_q != 2'h0 && $past(panel_type) inside {HBSP_PNL_MONO4, HBSP_PNL_COL4}
    |-> panel_data_bus_out[7:0] == {$past(pixel_data[3:0]), 4'h0}) else $error("nibble");
  chk_inv_gate: assert property (
    age_q != 2'h0 |-> video_invert == ($past(ctrl_reg[1]) && $past(panel_type) != HBSP_PNL_TFT
    && $past(panel_data_bus_in[11]))) else $error("invert");
  chk_gpio_dir: assert property (
    age_q != 2'h0 && $past(panel_type) != HBSP_PNL_TFT
    |-> panel_data_bus_oe_n[10:8] == ~$past(gpio_dir_out[2:0])) else $error("gpio oe");
  cover property (bus_cfg.bus == HBSP_BUS_GEN2);
  cover property (video_invert);
  cover property (panel_data_bus_oe_n == 12'h000);
endmodule
bind hbsp_strap_pin_map hbsp_chk #(.PANEL_WIDTH(PANEL_WIDTH)) i_chk (.*);
`default_nettype wire

/* File: tb/hbsp_panel_model.sv */
// panel and board side of the shared data pins
// assumes released pins float to ext, all ones being the pull-ups
`timescale 1ns/10ps
`default_nettype none
module hbsp_panel_model (
  input wire logic [11:0] drv,
  input wire logic [11:0] oe_n,
  input wire logic [11:0] ext,
  output logic [11:0] lvl
);
  assign lvl = (drv & ~oe_n) | (ext & oe_n);
endmodule
`default_nettype wire

/* File: tb/test_hbsp_strap_pin_map.sv */
// bench for strap capture and pin routing
// assumes the checker is bound in and the model closes the pins
`timescale 1ns/10ps
`default_nettype none
module test_hbsp_strap_pin_map;
  import hbsp_pkg::*;
  logic clk_sys = 0, sys_rst = 1, bus_start_strobe_n = 0, video_invert;
  logic [3:0] config_straps = 0, gpio_out = 4'h2, gpio_dir_out = 4'h3, gpio_in;
  logic [7:0] ctrl_reg = 0;
  logic [11:0] pixel_data = 12'hA5C, ext = 12'h800;
  logic [11:0] panel_data_bus_in, panel_data_bus_out, panel_data_bus_oe_n;
  hbsp_pnl_e panel_type = HBSP_PNL_TFT;
  hbsp_cfg_s bus_cfg;
  int err_total = 0, check_count = 0;
  logic [9:0] cases [16] = '{10'h202, 10'h000, 10'h246, 10'h044, 10'h2CA, 10'h0DD, 10'h34E,
    10'h15D, 10'h3D2, 10'h1D0, 10'h1F4, 10'h3FF, 10'h09D, 10'h29F, 10'h13D, 10'h39F};
  hbsp_strap_pin_map i_dut (.*);
  hbsp_panel_model i_pnl (.drv(panel_data_bus_out), .oe_n(panel_data_bus_oe_n), .ext(ext),
    .lvl(panel_data_bus_in));
  initial forever #50 clk_sys = ~clk_sys;
  task automatic check(logic [11:0] seen, logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (err_total == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // late strap changes must not reach the captured config
  task automatic boot(logic [4:0] s, logic [4:0] exp);
    {config_straps, bus_start_strobe_n} = s;
    sys_rst = 1;
    repeat (16) @(posedge clk_sys);
    #1 check(panel_data_bus_oe_n, 12'hF00);
    sys_rst = 0;
    repeat (2) @(posedge clk_sys);
    #1 check(bus_cfg, exp);
    config_straps = ~config_straps;
    @(posedge clk_sys);
    #1 check(bus_cfg, exp);
  endtask
  // every panel type, invert enabled, two gpio pins driven
  task automatic pins();
    ctrl_reg = 8'h02;
    for (int t = 0; t < 8; t++) begin
      panel_type = hbsp_pnl_e'(t);
      repeat (3) @(posedge clk_sys);
      #1 check(panel_data_bus_out[7:0], (t == 0 || t == 3) ? 8'hC0 : 8'h5C);
      check(video_invert, t != 7);
      check(gpio_in, 4'hA);
    end
  endtask
  initial begin
    foreach (cases[i]) begin
      boot(cases[i][9:5], cases[i][4:0]);
    end
    pins();
    final_report();
  end
  initial begin
    #200000;
    err_total++;
    final_report();
  end
endmodule
`default_nettype wire
